// *** iag_pkg.sv ***
// package for the indirect address generator: widths, mode codes, reset values
// assumes a single processor clock domain
package iag_pkg;
  // ==========================================================================
  // widths
  localparam int IAG_INSN_W = 16;
  localparam int IAG_PTR_W  = 9;
  localparam int IAG_ROM_W  = 16;
  localparam int IAG_SHORT_W = 9;
  // ==========================================================================
  // reset values
  localparam logic [IAG_PTR_W-1:0] IAG_PTR_RST = 9'h000;
  localparam logic [IAG_ROM_W-1:0] IAG_ROM_RST = 16'h0000;
  // ==========================================================================
  // register select for loads (short immediate and full immediate)
  typedef enum logic [3:0] {
    IAG_SEL_R0, IAG_SEL_R1, IAG_SEL_R2, IAG_SEL_R3,
    IAG_SEL_J, IAG_SEL_K, IAG_SEL_BASE, IAG_SEL_LAST,
    IAG_SEL_PT, IAG_SEL_I, IAG_SEL_NONE
  } iag_sel_t;
  // ==========================================================================
  // ram access post-modification modes
  typedef enum logic [1:0] {
    IAG_RAM_KEEP, IAG_RAM_INC, IAG_RAM_DEC, IAG_RAM_STEP
  } iag_ram_mode_t;
endpackage : iag_pkg

// *** iag_ptr_step.sv ***
// pointer post-modification arithmetic for one ram pointer
// assumes operands from the same clock domain
`timescale 1ns/1ps
`default_nettype none
module iag_ptr_step
  import iag_pkg::*;
(
  input  wire logic [IAG_PTR_W-1:0] cur,
  input  wire logic [1:0]           mode,
  input  wire logic [IAG_PTR_W-1:0] step,
  input  wire logic [IAG_PTR_W-1:0] mod_base,
  input  wire logic [IAG_PTR_W-1:0] mod_last,
  output var  logic [IAG_PTR_W-1:0] nxt
);
  // ==========================================================================
  // next pointer value
  always_comb begin
    case (iag_ram_mode_t'(mode))
      IAG_RAM_KEEP: nxt = cur;
      IAG_RAM_INC: begin
        if (cur == mod_last) nxt = mod_base;
        else nxt = cur + 9'h001;
      end
      IAG_RAM_DEC: nxt = cur - 9'h001;
      IAG_RAM_STEP: nxt = cur + step;
      default: nxt = cur;
    endcase
  end
endmodule : iag_ptr_step
`default_nettype wire

// *** iag_indirect_address_generator.sv ***
// indirect address generator: ram pointers, rom pointer, modulo wrap, loads
// assumes decoded requests from the processor on the same clock
//
// Function
// - every instruction word carrying a request is 16 bits wide.
// - a full immediate load takes its operand from the next program word, one extra cycle.
// - a short immediate load sets the ram pointers, steps and modulo registers from the word.
// - a short immediate load completes in one cycle from a single word.
// - a rom access reads the word at the rom pointer then adds one or the signed rom step.
// - a ram access uses one of four pointers chosen by index 0 to 3 as its address.
// - plain indirect mode leaves the pointer unchanged.
// - post-increment uses the current value then adds one.
// - post-decrement uses the current value then subtracts one.
// - register-step mode adds the signed step register j after the access.
// - modulo base holds the first and modulo last the last buffer address.
// - a pointer equal to modulo last under post-increment takes modulo base instead.
`timescale 1ns/1ps
`default_nettype none
module iag_indirect_address_generator
  import iag_pkg::*;
(
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  input  wire logic                  insn_valid,
  input  wire logic [IAG_INSN_W-1:0] insn_word,
  input  wire logic [3:0]            load_sel,
  input  wire logic                  short_load,
  input  wire logic                  long_load,
  input  wire logic                  ram_req,
  input  wire logic [1:0]            ram_ptr_sel,
  input  wire logic [1:0]            ram_mode,
  input  wire logic                  rom_req,
  input  wire logic                  rom_step_sel,
  input  wire logic [IAG_ROM_W-1:0]  rom_rdata,
  output logic [IAG_PTR_W-1:0]       ram_addr,
  output logic                       ram_addr_valid,
  output logic [IAG_ROM_W-1:0]       rom_addr,
  output logic                       rom_addr_valid,
  output logic [IAG_ROM_W-1:0]       mult_in,
  output logic                       mult_in_valid,
  output logic                       load_busy
);
  // ==========================================================================
  // state
  logic [IAG_PTR_W-1:0] ram_pointer_n_reg [4];
  logic [IAG_PTR_W-1:0] step_j_reg;
  logic [IAG_PTR_W-1:0] step_k_reg;
  logic [IAG_PTR_W-1:0] modulo_base_ptr_reg;
  logic [IAG_PTR_W-1:0] modulo_last_addr_reg;
  logic [IAG_ROM_W-1:0] rom_operand_pointer_reg;
  logic [IAG_ROM_W-1:0] rom_step_reg;
  logic [IAG_PTR_W-1:0] ram_addr_reg;
  logic                 ram_addr_valid_reg;
  logic                 rom_addr_valid_reg;
  logic [IAG_ROM_W-1:0] mult_in_reg;
  logic                 mult_in_valid_reg;
  logic                 load_busy_reg;
  logic [3:0]           load_sel_reg;
  logic [IAG_PTR_W-1:0] ptr_cur;
  logic [IAG_PTR_W-1:0] ptr_next;
  logic [IAG_PTR_W-1:0] short_val;
  logic                 ins_ok;
  logic                 long_done;

  assign ins_ok    = insn_valid && !load_busy_reg;
  assign short_val = insn_word[IAG_SHORT_W-1:0];
  assign long_done = insn_valid && load_busy_reg;
  assign ptr_cur   = ram_pointer_n_reg[ram_ptr_sel];

  iag_ptr_step u_step (
    .cur      (ptr_cur),
    .mode     (ram_mode),
    .step     (step_j_reg),
    .mod_base (modulo_base_ptr_reg),
    .mod_last (modulo_last_addr_reg),
    .nxt      (ptr_next)
  );

  // ==========================================================================
  // load select match for one register index
  function automatic logic write_hit(input logic [3:0] sel, input iag_sel_t tgt);
    write_hit = (sel == 4'(tgt));
  endfunction : write_hit

  // ==========================================================================
  // full immediate sequencing: operand word follows the instruction
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      load_busy_reg <= 1'b0;
      load_sel_reg  <= 4'h0;
    end else if (ins_ok && long_load) begin
      load_busy_reg <= 1'b1;
      load_sel_reg  <= load_sel;
    end else if (long_done) begin
      load_busy_reg <= 1'b0;
    end
  end

  // ==========================================================================
  // ram pointers: loads win over post-modification of the same pointer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int n = 0; n < 4; n++) ram_pointer_n_reg[n] <= IAG_PTR_RST;
    end else begin
      if (ins_ok && ram_req)
        ram_pointer_n_reg[ram_ptr_sel] <= ptr_next;
      for (int n = 0; n < 4; n++) begin
        if (ins_ok && short_load && write_hit(load_sel, iag_sel_t'(n)))
          ram_pointer_n_reg[n] <= short_val;
        if (long_done && write_hit(load_sel_reg, iag_sel_t'(n)))
          ram_pointer_n_reg[n] <= insn_word[IAG_PTR_W-1:0];
      end
    end
  end

  // ==========================================================================
  // step and modulo registers
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      step_j_reg           <= IAG_PTR_RST;
      step_k_reg           <= IAG_PTR_RST;
      modulo_base_ptr_reg  <= IAG_PTR_RST;
      modulo_last_addr_reg <= IAG_PTR_RST;
    end else if (ins_ok && short_load) begin
      if (write_hit(load_sel, IAG_SEL_J))    step_j_reg <= short_val;
      if (write_hit(load_sel, IAG_SEL_K))    step_k_reg <= short_val;
      if (write_hit(load_sel, IAG_SEL_BASE)) modulo_base_ptr_reg <= short_val;
      if (write_hit(load_sel, IAG_SEL_LAST)) modulo_last_addr_reg <= short_val;
    end else if (long_done) begin
      if (write_hit(load_sel_reg, IAG_SEL_J))    step_j_reg <= insn_word[IAG_PTR_W-1:0];
      if (write_hit(load_sel_reg, IAG_SEL_K))    step_k_reg <= insn_word[IAG_PTR_W-1:0];
      if (write_hit(load_sel_reg, IAG_SEL_BASE)) modulo_base_ptr_reg <= insn_word[IAG_PTR_W-1:0];
      if (write_hit(load_sel_reg, IAG_SEL_LAST)) modulo_last_addr_reg <= insn_word[IAG_PTR_W-1:0];
    end
  end

  // ==========================================================================
  // rom pointer and rom step
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rom_operand_pointer_reg <= IAG_ROM_RST;
      rom_step_reg            <= IAG_ROM_RST;
    end else if (long_done) begin
      if (write_hit(load_sel_reg, IAG_SEL_PT)) rom_operand_pointer_reg <= insn_word;
      if (write_hit(load_sel_reg, IAG_SEL_I))  rom_step_reg <= insn_word;
    end else if (ins_ok && rom_req) begin
      if (rom_step_sel)
        rom_operand_pointer_reg <= rom_operand_pointer_reg + rom_step_reg;
      else
        rom_operand_pointer_reg <= rom_operand_pointer_reg + 16'h0001;
    end
  end

  // ==========================================================================
  // address outputs and multiplier input capture
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ram_addr_reg       <= IAG_PTR_RST;
      ram_addr_valid_reg <= 1'b0;
      rom_addr_valid_reg <= 1'b0;
      mult_in_reg        <= IAG_ROM_RST;
      mult_in_valid_reg  <= 1'b0;
    end else begin
      ram_addr_valid_reg <= ins_ok && ram_req;
      if (ins_ok && ram_req)
        ram_addr_reg <= ptr_cur;
      rom_addr_valid_reg <= ins_ok && rom_req;
      mult_in_valid_reg  <= rom_addr_valid_reg;
      if (rom_addr_valid_reg)
        mult_in_reg <= rom_rdata;
    end
  end

  // rom address is the pointer value before its post-modification
  logic [IAG_ROM_W-1:0] rom_addr_reg;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) rom_addr_reg <= IAG_ROM_RST;
    else if (ins_ok && rom_req) rom_addr_reg <= rom_operand_pointer_reg;
  end

  assign ram_addr       = ram_addr_reg;
  assign ram_addr_valid = ram_addr_valid_reg;
  assign rom_addr       = rom_addr_reg;
  assign rom_addr_valid = rom_addr_valid_reg;
  assign mult_in        = mult_in_reg;
  assign mult_in_valid  = mult_in_valid_reg;
  assign load_busy      = load_busy_reg;

  // ==========================================================================
  // checks
  post_inc_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ins_ok && ram_req && !short_load && !long_done && ram_mode == 2'h1
      && ptr_cur != modulo_last_addr_reg
    |=> ram_pointer_n_reg[$past(ram_ptr_sel)] == $past(ptr_cur) + 9'h001)
    else $error("post increment wrong");
  post_dec_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ins_ok && ram_req && !short_load && !long_done && ram_mode == 2'h2
    |=> ram_pointer_n_reg[$past(ram_ptr_sel)] == $past(ptr_cur) - 9'h001)
    else $error("post decrement wrong");
  keep_ptr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ins_ok && ram_req && !short_load && !long_done && ram_mode == 2'h0
    |=> ram_pointer_n_reg[$past(ram_ptr_sel)] == $past(ptr_cur))
    else $error("plain mode changed pointer");
  step_ptr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ins_ok && ram_req && !short_load && !long_done && ram_mode == 2'h3
    |=> ram_pointer_n_reg[$past(ram_ptr_sel)] == $past(ptr_cur) + $past(step_j_reg))
    else $error("step mode wrong");
  modulo_wrap_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ins_ok && ram_req && !short_load && !long_done && ram_mode == 2'h1
      && ptr_cur == modulo_last_addr_reg
    |=> ram_pointer_n_reg[$past(ram_ptr_sel)] == $past(modulo_base_ptr_reg))
    else $error("modulo wrap missed");
  ram_addr_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ins_ok && ram_req |=> ram_addr_valid && ram_addr == $past(ptr_cur))
    else $error("ram address not current pointer");
  rom_inc_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ins_ok && rom_req && !rom_step_sel
    |=> rom_operand_pointer_reg == $past(rom_operand_pointer_reg) + 16'h0001
        ##1 mult_in_valid && mult_in == $past(rom_rdata))
    else $error("rom access wrong");
  long_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ins_ok && long_load |=> load_busy ##1 (!load_busy || !$past(insn_valid)))
    else $error("long load sequencing wrong");
  short_load_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ins_ok && short_load && load_sel == 4'h6 |=> modulo_base_ptr_reg == $past(short_val)
      && !load_busy)
    else $error("short load not single cycle");
endmodule : iag_indirect_address_generator
`default_nettype wire

// *** iag_rom_model.sv ***
// rom data memory model answering rom operand reads of the address generator
// assumes rom_addr and rom_addr_valid registered on sys_clk
`timescale 1ns/1ps
`default_nettype none
module iag_rom_model
  import iag_pkg::*;
#(
  parameter logic [IAG_ROM_W-1:0] ROM_XOR = 16'hc3a5
)(
  input  wire logic                 sys_clk,
  input  wire logic [IAG_ROM_W-1:0] rom_addr,
  input  wire logic                 rom_addr_valid,
  output var  logic [IAG_ROM_W-1:0] rom_rdata
);
  // ==========================================================================
  // junk pattern while no read is open, changes every cycle
  logic [IAG_ROM_W-1:0] junk_reg = 16'h0f0f;
  always @(posedge sys_clk) begin
    junk_reg <= ~junk_reg + 16'h1357;
  end
  // ==========================================================================
  // word at the addressed location
  assign rom_rdata = rom_addr_valid ? (rom_addr ^ ROM_XOR) : junk_reg;
endmodule : iag_rom_model
`default_nettype wire

// *** iag_indirect_address_generator_bench.sv ***
// self-checking bench for the indirect address generator
// assumes the rom model as far side, 125 mhz clock, active low async reset
`timescale 1ns/1ps
`default_nettype none
module iag_indirect_address_generator_bench;
  import iag_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        insn_valid = 1'b0;
  logic [15:0] insn_word = 16'h0000;
  logic [3:0]  load_sel = 4'h0;
  logic        short_load = 1'b0;
  logic        long_load = 1'b0;
  logic        ram_req = 1'b0;
  logic [1:0]  ram_ptr_sel = 2'h0;
  logic [1:0]  ram_mode = 2'h0;
  logic        rom_req = 1'b0;
  logic        rom_step_sel = 1'b0;
  logic [15:0] rom_rdata;
  logic [8:0]  ram_addr;
  logic        ram_addr_valid;
  logic [15:0] rom_addr;
  logic        rom_addr_valid;
  logic [15:0] mult_in;
  logic        mult_in_valid;
  logic        load_busy;
  int          n_errors = 0;
  int          compares = 0;
  always #4 sys_clk = ~sys_clk;
  iag_indirect_address_generator i_dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .insn_valid(insn_valid), .insn_word(insn_word), .load_sel(load_sel),
    .short_load(short_load), .long_load(long_load), .ram_req(ram_req),
    .ram_ptr_sel(ram_ptr_sel), .ram_mode(ram_mode), .rom_req(rom_req),
    .rom_step_sel(rom_step_sel), .rom_rdata(rom_rdata), .ram_addr(ram_addr),
    .ram_addr_valid(ram_addr_valid), .rom_addr(rom_addr),
    .rom_addr_valid(rom_addr_valid), .mult_in(mult_in),
    .mult_in_valid(mult_in_valid), .load_busy(load_busy));
  iag_rom_model i_rom (.sys_clk(sys_clk), .rom_addr(rom_addr),
    .rom_addr_valid(rom_addr_valid), .rom_rdata(rom_rdata));
  // ==========================================================================
  // helpers
  task automatic summarize();
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    compares++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", nm, exp, got);
      n_errors++;
    end
  endtask : chk
  // one request cycle, returns just after the edge that takes it
  task automatic cyc(input logic v, sl, ll, rr, ro, input logic [3:0] ls,
                     input logic [15:0] w, input logic [1:0] ps, md, input logic rs);
    insn_valid = v; short_load = sl; long_load = ll; ram_req = rr; rom_req = ro;
    load_sel = ls; insn_word = w; ram_ptr_sel = ps; ram_mode = md; rom_step_sel = rs;
    @(posedge sys_clk);
    #1;
  endtask : cyc
  task automatic sload(input logic [3:0] ls, input logic [8:0] val);
    cyc(1, 1, 0, 0, 0, ls, {7'h00, val}, 2'h0, 2'h0, 0);
  endtask : sload
  task automatic ram(input logic [1:0] ps, md, input logic [8:0] exp);
    cyc(1, 0, 0, 1, 0, 4'h0, 16'h0000, ps, md, 0);
    chk("ram_addr_valid", 16'h0001, {15'h0000, ram_addr_valid});
    chk("ram_addr", {7'h00, exp}, {7'h00, ram_addr});
  endtask : ram
  // ==========================================================================
  // scenarios
  task automatic t_loads();
    logic [8:0] v [4] = '{9'h005, 9'h1ff, 9'h000, 9'h0a0};
    for (int i = 0; i < 4; i++) sload(i[3:0], v[i]);
    sload(4'h4, 9'h1fd);
    sload(4'h6, 9'h010);
    sload(4'h7, 9'h012);
    for (int k = 0; k < 2; k++)
      for (int i = 0; i < 4; i++) ram(i[1:0], 2'h0, v[i]);
    $display("test loads done");
  endtask : t_loads
  task automatic t_modes();
    ram(2'h0, 2'h1, 9'h005);
    ram(2'h0, 2'h0, 9'h006);
    ram(2'h1, 2'h1, 9'h1ff);
    ram(2'h1, 2'h0, 9'h000);
    ram(2'h2, 2'h2, 9'h000);
    ram(2'h2, 2'h0, 9'h1ff);
    ram(2'h3, 2'h3, 9'h0a0);
    ram(2'h3, 2'h0, 9'h09d);
    $display("test modes done");
  endtask : t_modes
  task automatic t_modulo();
    sload(4'h0, 9'h011);
    ram(2'h0, 2'h1, 9'h011);
    ram(2'h0, 2'h1, 9'h012);
    ram(2'h0, 2'h1, 9'h010);
    sload(4'h1, 9'h012);
    ram(2'h1, 2'h2, 9'h012);
    ram(2'h1, 2'h0, 9'h011);
    $display("test modulo done");
  endtask : t_modulo
  task automatic t_long();
    cyc(1, 0, 1, 0, 0, 4'h8, 16'h8000, 2'h0, 2'h0, 0);
    chk("load_busy", 16'h0001, {15'h0000, load_busy});
    cyc(1, 0, 0, 1, 0, 4'h0, 16'h1234, 2'h0, 2'h0, 0);
    chk("ram_addr_valid", 16'h0000, {15'h0000, ram_addr_valid});
    chk("load_busy", 16'h0000, {15'h0000, load_busy});
    cyc(1, 0, 1, 0, 0, 4'h9, 16'h0000, 2'h0, 2'h0, 0);
    cyc(1, 0, 0, 0, 0, 4'h0, 16'hfffe, 2'h0, 2'h0, 0);
    cyc(1, 0, 0, 0, 1, 4'h0, 16'h0000, 2'h0, 2'h0, 0);
    chk("rom_addr", 16'h1234, rom_addr);
    chk("rom_addr_valid", 16'h0001, {15'h0000, rom_addr_valid});
    cyc(1, 0, 0, 0, 1, 4'h0, 16'h0000, 2'h0, 2'h0, 1);
    chk("rom_addr", 16'h1235, rom_addr);
    chk("mult_in", 16'h1234 ^ 16'hc3a5, mult_in);
    chk("mult_in_valid", 16'h0001, {15'h0000, mult_in_valid});
    cyc(1, 0, 0, 0, 1, 4'h0, 16'h0000, 2'h0, 2'h0, 0);
    chk("rom_addr", 16'h1233, rom_addr);
    chk("mult_in", 16'h1235 ^ 16'hc3a5, mult_in);
    cyc(0, 0, 0, 0, 0, 4'h0, 16'h0000, 2'h0, 2'h0, 0);
    chk("mult_in", 16'h1233 ^ 16'hc3a5, mult_in);
    cyc(0, 0, 0, 0, 0, 4'h0, 16'h0000, 2'h0, 2'h0, 0);
    chk("mult_in_valid", 16'h0000, {15'h0000, mult_in_valid});
    cyc(1, 0, 1, 0, 0, 4'h2, 16'h0000, 2'h0, 2'h0, 0);
    chk("load_busy", 16'h0001, {15'h0000, load_busy});
    cyc(1, 0, 0, 0, 0, 4'h0, 16'h1abc, 2'h0, 2'h0, 0);
    ram(2'h2, 2'h0, 9'h0bc);
    $display("test long done");
  endtask : t_long
  // ==========================================================================
  // main sequence and watchdog
  initial begin
    repeat (3) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    t_loads();
    t_modes();
    t_modulo();
    t_long();
    summarize();
  end
  initial begin
    repeat (2000) @(posedge sys_clk);
    n_errors++;
    summarize();
  end
endmodule : iag_indirect_address_generator_bench
`default_nettype wire
